// *** inc/pdc_defs.vh ***
// Offsets, field positions, reset values and widths of the PLL divider configuration bank
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// ****************************************************************
// Register offsets (byte registers on the management port)
// ****************************************************************
`define PDC_ADDR_OUT2_MID 8'h23
`define PDC_ADDR_OUT2_LOW 8'h24
`define PDC_ADDR_FB_HS 8'h28
`define PDC_ADDR_FB_LS_MID 8'h29
`define PDC_ADDR_FB_LS_LOW 8'h2A
`define PDC_ADDR_IN1_TOP 8'h2B
`define PDC_ADDR_IN1_MID 8'h2C
`define PDC_ADDR_IN1_LOW 8'h2D

// ****************************************************************
// Field positions
// ****************************************************************
`define PDC_FB_HS_MSB 7
`define PDC_FB_HS_LSB 5
`define PDC_FB_LS_TOP_MSB 3
`define PDC_FB_LS_TOP_LSB 0
`define PDC_IN1_TOP_MSB 2
`define PDC_IN1_TOP_LSB 0

// ****************************************************************
// Reset values
// ****************************************************************
`define PDC_RST_OUT2_MID 8'h00
`define PDC_RST_OUT2_LOW 8'h31
`define PDC_RST_FB_HS 8'hC0
`define PDC_RST_FB_LS_MID 8'h00
`define PDC_RST_FB_LS_LOW 8'hF9
`define PDC_RST_IN1_TOP 8'h00
`define PDC_RST_IN1_MID 8'h00
`define PDC_RST_IN1_LOW 8'h09

// ****************************************************************
// Divider widths and the fixed offset of the high-speed terminal count
// ****************************************************************
`define PDC_CNT_W 20
`define PDC_HS_TERM_OFS 20'h00003

`endif

// *** src/pdc_regs.v ***
// PLL divider configuration register bank with the dividers it steers
`timescale 1ns/1ps
`include "pdc_defs.vh"

module pdc_regs (
   // Clock and reset
   input wire mclk,
   input wire reset_n,
   // Register access from the serial management port logic
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_reg,
   // Source ticks from logic on the same clock
   input wire input_clock_one_tick,
   input wire fb_src_tick,
   input wire out2_src_tick,
   // Divided ticks
   output reg in1_prediv_tick_reg,
   output reg feedback_ls_stage_tick_reg,
   output reg output_clock_two_tick_reg,
   // Applied divider settings
   output reg [15:0] out2_lowspeed_div_reg,
   output reg [2:0] fb_highspeed_div_reg,
   output reg [19:0] fb_lowspeed_div_reg,
   output reg [18:0] in1_prediv_reg
);

   // ****************************************************************
   // Reset release
   // ****************************************************************
   reg rst_meta_reg;
   reg rst_sync_reg;

   // Two-stage release so every flop leaves reset on the same edge
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // ****************************************************************
   // Register storage
   // ****************************************************************
   reg [7:0] out2_div_mid_byte_reg;
   reg [7:0] out2_div_low_byte_reg;
   reg [2:0] fb_hs_code_reg;
   reg [3:0] fb_ls_top_reg;
   reg [7:0] fb_ls_div_mid_byte_reg;
   reg [7:0] fb_ls_div_low_byte_reg;
   reg [2:0] in1_prediv_top_bits_reg;
   reg [7:0] in1_prediv_mid_byte_reg;
   reg [7:0] in1_prediv_low_byte_reg;

   // Reset images of the mixed registers; fields are sliced out so no bits are dropped by accident
   localparam [7:0] fb_hs_rst_val = `PDC_RST_FB_HS;
   localparam [7:0] in1_top_rst_val = `PDC_RST_IN1_TOP;

   // Byte writes; reserved bits are simply not stored
   always @(posedge mclk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         out2_div_mid_byte_reg <= `PDC_RST_OUT2_MID;
         out2_div_low_byte_reg <= `PDC_RST_OUT2_LOW;
         fb_hs_code_reg <= fb_hs_rst_val[`PDC_FB_HS_MSB:`PDC_FB_HS_LSB];
         fb_ls_top_reg <= fb_hs_rst_val[`PDC_FB_LS_TOP_MSB:`PDC_FB_LS_TOP_LSB];
         fb_ls_div_mid_byte_reg <= `PDC_RST_FB_LS_MID;
         fb_ls_div_low_byte_reg <= `PDC_RST_FB_LS_LOW;
         in1_prediv_top_bits_reg <= in1_top_rst_val[`PDC_IN1_TOP_MSB:`PDC_IN1_TOP_LSB];
         in1_prediv_mid_byte_reg <= `PDC_RST_IN1_MID;
         in1_prediv_low_byte_reg <= `PDC_RST_IN1_LOW;
      end else if (reg_wr) begin
         case (reg_addr)
            `PDC_ADDR_OUT2_MID: begin
               out2_div_mid_byte_reg <= reg_wdata;
            end
            `PDC_ADDR_OUT2_LOW: begin
               out2_div_low_byte_reg <= reg_wdata;
            end
            `PDC_ADDR_FB_HS: begin
               fb_hs_code_reg <= reg_wdata[`PDC_FB_HS_MSB:`PDC_FB_HS_LSB];
               fb_ls_top_reg <= reg_wdata[`PDC_FB_LS_TOP_MSB:`PDC_FB_LS_TOP_LSB];
            end
            `PDC_ADDR_FB_LS_MID: begin
               fb_ls_div_mid_byte_reg <= reg_wdata;
            end
            `PDC_ADDR_FB_LS_LOW: begin
               fb_ls_div_low_byte_reg <= reg_wdata;
            end
            `PDC_ADDR_IN1_TOP: begin
               in1_prediv_top_bits_reg <= reg_wdata[`PDC_IN1_TOP_MSB:`PDC_IN1_TOP_LSB];
            end
            `PDC_ADDR_IN1_MID: begin
               in1_prediv_mid_byte_reg <= reg_wdata;
            end
            `PDC_ADDR_IN1_LOW: begin
               in1_prediv_low_byte_reg <= reg_wdata;
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Read back
   // ****************************************************************
   reg [7:0] rd_mux;

   // Reserved positions and unmapped offsets return zero
   always @* begin
      rd_mux = 8'h00;
      case (reg_addr)
         `PDC_ADDR_OUT2_MID: begin
            rd_mux = out2_div_mid_byte_reg;
         end
         `PDC_ADDR_OUT2_LOW: begin
            rd_mux = out2_div_low_byte_reg;
         end
         `PDC_ADDR_FB_HS: begin
            rd_mux = {fb_hs_code_reg, 1'b0, fb_ls_top_reg};
         end
         `PDC_ADDR_FB_LS_MID: begin
            rd_mux = fb_ls_div_mid_byte_reg;
         end
         `PDC_ADDR_FB_LS_LOW: begin
            rd_mux = fb_ls_div_low_byte_reg;
         end
         `PDC_ADDR_IN1_TOP: begin
            rd_mux = {5'h00, in1_prediv_top_bits_reg};
         end
         `PDC_ADDR_IN1_MID: begin
            rd_mux = in1_prediv_mid_byte_reg;
         end
         `PDC_ADDR_IN1_LOW: begin
            rd_mux = in1_prediv_low_byte_reg;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // Read data is held until the next read strobe
   always @(posedge mclk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         reg_rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata_reg <= rd_mux;
      end
   end

   // ****************************************************************
   // Field assembly and terminal counts
   // ****************************************************************

   // Ratio n+1 means the counter wraps at the field value itself
   function [`PDC_CNT_W-1:0] term_of_field;
      input [`PDC_CNT_W-1:0] field;
      begin
         term_of_field = field;
      end
   endfunction

   wire [15:0] out2_field;
   wire [19:0] fb_ls_field;
   wire [18:0] in1_field;
   wire [`PDC_CNT_W-1:0] out2_term;
   wire [`PDC_CNT_W-1:0] fb_ls_term;
   wire [`PDC_CNT_W-1:0] in1_term;
   wire [`PDC_CNT_W-1:0] fb_hs_term;

   // Upper output-two bits live outside this bank and count as zero here
   assign out2_field = {out2_div_mid_byte_reg, out2_div_low_byte_reg};
   assign fb_ls_field = {fb_ls_top_reg, fb_ls_div_mid_byte_reg, fb_ls_div_low_byte_reg};
   assign in1_field = {in1_prediv_top_bits_reg, in1_prediv_mid_byte_reg, in1_prediv_low_byte_reg};
   assign out2_term = term_of_field({4'h0, out2_field});
   assign fb_ls_term = term_of_field(fb_ls_field);
   assign in1_term = term_of_field({1'b0, in1_field});
   // Codes 0..7 give ratios 4..11, so wrap at code plus three
   assign fb_hs_term = {17'h00000, fb_hs_code_reg} + `PDC_HS_TERM_OFS;

   // ****************************************************************
   // Dividers
   // ****************************************************************
   wire in1_tick;
   wire fb_hs_tick;
   wire fb_ls_tick;
   wire out2_tick;

   // Pre-divider on input clock one
   pdc_tick_div u_in1_div (
      .mclk(mclk),
      .rst_n(rst_sync_reg),
      .src_tick(input_clock_one_tick),
      .term_cnt(in1_term),
      .out_tick_reg(in1_tick)
   );

   // Feedback high-speed stage clocks the low-speed stage
   pdc_tick_div u_fb_hs_div (
      .mclk(mclk),
      .rst_n(rst_sync_reg),
      .src_tick(fb_src_tick),
      .term_cnt(fb_hs_term),
      .out_tick_reg(fb_hs_tick)
   );

   // Feedback low-speed stage feeds the phase detector
   pdc_tick_div u_fb_ls_div (
      .mclk(mclk),
      .rst_n(rst_sync_reg),
      .src_tick(fb_hs_tick),
      .term_cnt(fb_ls_term),
      .out_tick_reg(fb_ls_tick)
   );

   // Output-two low-speed divider
   pdc_tick_div u_out2_div (
      .mclk(mclk),
      .rst_n(rst_sync_reg),
      .src_tick(out2_src_tick),
      .term_cnt(out2_term),
      .out_tick_reg(out2_tick)
   );

   // ****************************************************************
   // Output flops
   // ****************************************************************

   // Every output is registered; ticks lag their divider by one cycle
   always @(posedge mclk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         in1_prediv_tick_reg <= 1'b0;
         feedback_ls_stage_tick_reg <= 1'b0;
         output_clock_two_tick_reg <= 1'b0;
         out2_lowspeed_div_reg <= {`PDC_RST_OUT2_MID, `PDC_RST_OUT2_LOW};
         fb_highspeed_div_reg <= fb_hs_rst_val[`PDC_FB_HS_MSB:`PDC_FB_HS_LSB];
         fb_lowspeed_div_reg <= {fb_hs_rst_val[`PDC_FB_LS_TOP_MSB:`PDC_FB_LS_TOP_LSB],
            `PDC_RST_FB_LS_MID, `PDC_RST_FB_LS_LOW};
         in1_prediv_reg <= {in1_top_rst_val[`PDC_IN1_TOP_MSB:`PDC_IN1_TOP_LSB],
            `PDC_RST_IN1_MID, `PDC_RST_IN1_LOW};
      end else begin
         in1_prediv_tick_reg <= in1_tick;
         feedback_ls_stage_tick_reg <= fb_ls_tick;
         output_clock_two_tick_reg <= out2_tick;
         out2_lowspeed_div_reg <= out2_field;
         fb_highspeed_div_reg <= fb_hs_code_reg;
         fb_lowspeed_div_reg <= fb_ls_field;
         in1_prediv_reg <= in1_field;
      end
   end

endmodule // pdc_regs

// *** src/pdc_tick_div.v ***
// Enable-pulse divider: one output tick per (terminal+1) input ticks
`timescale 1ns/1ps
`include "pdc_defs.vh"

module pdc_tick_div (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Source tick and terminal count (ratio minus one)
   input wire src_tick,
   input wire [`PDC_CNT_W-1:0] term_cnt,
   // Divided tick
   output reg out_tick_reg
);

   reg [`PDC_CNT_W-1:0] cnt_reg;

   // Count source ticks; wrap and tick on terminal. A terminal lowered
   // below the running count wraps at once, so a new ratio takes hold quickly.
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= {`PDC_CNT_W{1'b0}};
         out_tick_reg <= 1'b0;
      end else begin
         out_tick_reg <= 1'b0;
         if (src_tick) begin
            if (cnt_reg >= term_cnt) begin
               cnt_reg <= {`PDC_CNT_W{1'b0}};
               out_tick_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 20'h00001;
            end
         end
      end
   end

endmodule // pdc_tick_div

// *** testbench/pdc_regs_asserts.sv ***
// Port checker of the divider configuration bank
`timescale 1ns/1ps
module pdc_regs_asserts (
   // Clock and reset
   input wire mclk,
   input wire reset_n,
   // Register access
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata_reg,
   // Ticks and settings
   input wire out2_src_tick,
   input wire output_clock_two_tick_reg,
   input wire [15:0] out2_lowspeed_div_reg,
   input wire [2:0] fb_highspeed_div_reg,
   input wire [19:0] fb_lowspeed_div_reg,
   input wire [18:0] in1_prediv_reg
);
   // ***
   // Properties
   // ***
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // A write reaches its setting two edges after the strobe
   sequence s_wr(a);
      reg_wr && reg_addr == a;
   endsequence
   // A plain read, so the old value is not in doubt
   sequence s_rd(a);
      reg_rd && !reg_wr && reg_addr == a;
   endsequence
   a_out2_mid_use: assert property (s_wr(8'h23) |-> ##2 out2_lowspeed_div_reg[15:8] == $past(reg_wdata, 2))
      else $error("out2 middle byte not applied");
   a_out2_low_use: assert property (s_wr(8'h24) |-> ##2 out2_lowspeed_div_reg[7:0] == $past(reg_wdata, 2))
      else $error("out2 low byte not applied");
   a_hs_code_use: assert property (s_wr(8'h28) |-> ##2 fb_highspeed_div_reg == $past(reg_wdata[7:5], 2))
      else $error("high-speed code not applied");
   a_fb_top_use: assert property (s_wr(8'h28) |-> ##2 fb_lowspeed_div_reg[19:16] == $past(reg_wdata[3:0], 2))
      else $error("feedback top bits not applied");
   a_in1_top_use: assert property (s_wr(8'h2B) |-> ##2 in1_prediv_reg[18:16] == $past(reg_wdata[2:0], 2))
      else $error("pre-divider top bits not applied");
   a_hs_resv_zero: assert property (s_rd(8'h28) |=> !reg_rdata_reg[4])
      else $error("reserved bit of 0x28 reads one");
   a_in1_resv_zero: assert property (s_rd(8'h2B) |=> reg_rdata_reg[7:3] == 5'h00)
      else $error("reserved bits of 0x2B read nonzero");
   a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {8'h23, 8'h24, [8'h28:8'h2D]}) |=> reg_rdata_reg == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_reg))
      else $error("read data moved without a read");
   a_setting_hold: assert property (!reg_wr |-> ##2 $stable(out2_lowspeed_div_reg))
      else $error("out2 setting moved without a write");
   a_out2_tick_cause: assert property (output_clock_two_tick_reg |-> $past(out2_src_tick, 2))
      else $error("out2 tick without source tick");
endmodule // pdc_regs_asserts

bind pdc_regs pdc_regs_asserts u_chk (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_reg,
   .out2_src_tick, .output_clock_two_tick_reg, .out2_lowspeed_div_reg, .fb_highspeed_div_reg,
   .fb_lowspeed_div_reg, .in1_prediv_reg);

// *** testbench/test_pdc_regs.sv ***
// Self-checking bench of the divider configuration bank
`timescale 1ns/1ps
module test_pdc_regs;
   reg mclk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, tk_on = 0, rd_d = 0;
   reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   wire [7:0] rdata;
   wire t1, tf, t2;
   wire [15:0] o2;
   wire [2:0] hs;
   wire [19:0] fl;
   wire [18:0] i1;
   reg [7:0] q[$];
   reg [7:0] v [0:7];
   reg [7:0] ad [0:7] = '{8'h23, 8'h24, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
   reg [7:0] dv [0:7] = '{8'h00, 8'h31, 8'hC0, 8'h00, 8'hF9, 8'h00, 8'h00, 8'h09};
   reg [7:0] mk [0:7] = '{8'hFF, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF};
   integer err_count = 0, checks_done = 0, cyc = 0, seed = 32'hD90C8D0E, i, n;

   pdc_regs dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_reg(rdata), .input_clock_one_tick(tk_on), .fb_src_tick(tk_on),
      .out2_src_tick(tk_on), .in1_prediv_tick_reg(t1), .feedback_ls_stage_tick_reg(tf),
      .output_clock_two_tick_reg(t2), .out2_lowspeed_div_reg(o2), .fb_highspeed_div_reg(hs),
      .fb_lowspeed_div_reg(fl), .in1_prediv_reg(i1));

   // ***
   // Clock, tasks and read monitor
   // ***
   always #25 mclk = ~mclk;

   task chk(input string nm, input [19:0] e, input [19:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("unexpected %s exp %h got %h", nm, e, g);
         end
      end
   endtask

   // One strobe cycle; a read notes its expected byte for the monitor
   task op(input w, input [7:0] a, input [7:0] d);
      begin
         @(negedge mclk);
         reg_addr = a;
         reg_wdata = d;
         reg_wr = w;
         reg_rd = !w;
         if (!w) q.push_back(d);
         @(negedge mclk);
         reg_wr = 0;
         reg_rd = 0;
      end
   endtask

   // Read data is settled by the falling edge after the taking edge
   always @(posedge mclk) rd_d <= reg_rd;
   always @(negedge mclk) if (rd_d) chk("rdata", q.pop_front(), rdata);

   function tick(input integer s);
      tick = s == 0 ? t2 : (s == 1 ? t1 : tf);
   endfunction

   // Third interval is taken so a wrap after reprogramming cannot skew it
   task gap(input integer s, input [19:0] e);
      integer k;
      begin
         for (k = 0; k < 3; k = k + 1) begin
            n = 0;
            @(negedge mclk);
            while (!tick(s) && n < 100) begin
               n = n + 1;
               @(negedge mclk);
            end
         end
         chk("tick gap", e, n + 1);
      end
   endtask

   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         err_count = err_count + 1;
         end_of_test;
      end
   end

   // ***
   // Main sequence
   // ***
   initial begin
      #400 reset_n = 1;
      repeat (3) @(posedge mclk);
      for (i = 0; i < 8; i = i + 1) op(0, ad[i], dv[i]);
      chk("settings", {16'h0031, 3'h6}, {o2, hs});
      chk("fb ls", 20'h000F9, fl);
      chk("in1", 20'h00009, i1);
      $display("reset values done");
      for (i = 0; i < 8; i = i + 1) begin
         v[i] = 8'($random(seed)) | 8'(i == 1 || i == 4);
         op(1, ad[i], v[i]);
      end
      for (i = 0; i < 8; i = i + 1) op(0, ad[i], v[i] & mk[i]);
      op(1, 8'h25, 8'hA5);
      op(0, 8'h25, 8'h00);
      chk("out2", {v[0], v[1]}, o2);
      chk("fb hs", v[2][7:5], hs);
      chk("fb ls", {v[2][3:0], v[3], v[4]}, fl);
      chk("in1", {v[5][2:0], v[6], v[7]}, i1);
      $display("random access done");
      for (i = 0; i < 8; i = i + 1) op(1, ad[i], i == 1 ? 8'h03 : (i == 4 ? 8'h01 : (i == 7 ? 8'h02 : 8'h00)));
      tk_on = 1;
      gap(0, 4);
      gap(1, 3);
      for (i = 0; i < 8; i = i + 1) begin
         op(1, 8'h28, 8'(i << 5));
         gap(2, (i + 4) * 2);
      end
      $display("divider ratios done");
      reset_n = 0;
      repeat (2) @(negedge mclk);
      reset_n = 1;
      repeat (3) @(posedge mclk);
      op(0, 8'h24, 8'h31);
      op(0, 8'h28, 8'hC0);
      chk("out2", 16'h0031, o2);
      @(negedge mclk);
      $display("second reset done");
      end_of_test;
   end
endmodule // test_pdc_regs
